// [ssf_pkg.sv]
// ssf_pkg: constants, control carrier and state codes of the serial frame engine
// assumes: single 200 MHz system clock, control bits held stable while a frame runs
package ssf_pkg;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 16;
   localparam logic [3:0] FIFO_FULL = 4'h8;
   localparam logic [3:0] TX_SERVICE_LEVEL = 4'h4;
   localparam logic [3:0] RX_SERVICE_LEVEL = 4'h4;
   localparam logic [6:0] TIMEOUT_HALVES = 7'h40;
   localparam logic [4:0] MSG_CTRL_BITS = 5'h08;
   localparam logic [4:0] MSG_SKIP_BITS = 5'h09;
   localparam logic [5:0] PULSE_LEAD_HALVES = 6'h02;
   // interrupt bit positions
   localparam int INT_OVERRUN = 0;
   localparam int INT_TIMEOUT = 1;
   localparam int INT_RX = 2;
   localparam int INT_TX = 3;
   localparam logic [3:0] RAW_RESET = 4'h0;

   typedef enum logic [1:0] {
      FMT_SPI = 2'b00,
      FMT_PULSE = 2'b01,
      FMT_MSG = 2'b10
   } ssf_format_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LEAD = 3'b001,
      ST_XFER = 3'b010,
      ST_TAIL = 3'b011,
      ST_GAP = 3'b100
   } ssf_state_t;

   typedef struct packed {
      logic enable;
      logic master_mode;
      ssf_format_t frame_format;
      logic clock_polarity;
      logic clock_phase;
      logic [3:0] data_size_m1;
      logic [7:0] prescale_divisor;
      logic [7:0] serial_rate_value;
   } ssf_ctrl_t;
endpackage : ssf_pkg

// [ssf_engine.sv]
// ssf_engine: serial frame engine with fifos, bit-rate divider and interrupt status
// assumes: control inputs from on-chip logic on ref_clk; serial_in_pin is asynchronous
//
// Function
// - four events: tx service, rx service, timeout, overrun
// - enabled events ORed into one request
// - per-event mask, one enables
// - raw and masked status both readable
// - word of 4 to 16 bits, msb first
// - clock idle when idle, toggles in transfers
// - timeout when clock idle and rx holds data
// - select low whole frame in spi, message
// - pulse format: select high one period before
// - pulse format idle: clock, select low, tx hi-z
// - pulse format: load word with select pulse
// - pulse format: push rx on next rising edge
// - message: 8-bit control, wait, 4-16 reply bits
// - polarity sets clock idle level
// - phase picks first or second capture edge
// - idle: clock idle, select high; master drives clock
// - pol0 pha0: select low, data, then rise
// - pol0 pha0: sample rising, change falling
// - select high one period after last capture
// - phase 0: select pulses high between words
// - pha1: data with first edge, capture second
// - phase 1: select stays low between words
// - eight-entry 16-bit tx and rx fifos
// - clock = sys / (prescale * (1 + rate))
`timescale 1ns/10ps
`default_nettype none
module ssf_engine (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire ssf_pkg::ssf_ctrl_t control_zero_reg,
   input wire logic [3:0] interrupt_mask_reg,
   input wire logic overrun_clear,
   input wire logic tx_wr_valid,
   output logic tx_wr_ready,
   input wire logic [15:0] tx_wr_data,
   output logic rx_rd_valid,
   input wire logic rx_rd_ready,
   output logic [15:0] rx_rd_data,
   output logic [3:0] raw_interrupt_status,
   output logic [3:0] masked_interrupt_status,
   output logic interrupt_request,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   output logic frame_select_pin_o,
   output logic frame_select_pin_oe,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe,
   input wire logic serial_in_pin
);
   ssf_pkg::ssf_ctrl_t ctl;
   ssf_pkg::ssf_state_t state_q;
   logic is_spi, is_pulse, is_msg;
   logic rx_meta_q, rx_sync_q;
   logic [15:0] tx_mem [ssf_pkg::FIFO_DEPTH];
   logic [15:0] rx_mem [ssf_pkg::FIFO_DEPTH];
   logic [2:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [3:0] tx_cnt_q, rx_cnt_q;
   logic tx_push, tx_pop, rx_pop;
   logic [6:0] pre_q, pre_lim;
   logic [7:0] rate_q;
   logic half_tick, start;
   logic [5:0] half_q, last_half, h_n;
   logic [4:0] nbits, skip_bits;
   logic [15:0] tx_sh_q, rx_sh_q, load_word;
   logic sclk_q, fss_q, dout_q, doe_q;
   logic word_done, more;
   logic ovr_q;
   logic [6:0] to_cnt_q;
   logic [3:0] raw_q;

   assign ctl = control_zero_reg;
   assign is_spi = ctl.frame_format == ssf_pkg::FMT_SPI;
   assign is_pulse = ctl.frame_format == ssf_pkg::FMT_PULSE;
   assign is_msg = ctl.frame_format == ssf_pkg::FMT_MSG;

   // input synchroniser
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_meta_q <= 1'b0;
         rx_sync_q <= 1'b0;
      end else begin
         rx_meta_q <= serial_in_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   // transmit fifo
   assign tx_wr_ready = tx_cnt_q != ssf_pkg::FIFO_FULL;
   assign tx_push = tx_wr_valid && tx_wr_ready;
   always_ff @(posedge ref_clk) begin
      if (tx_push) begin
         tx_mem[tx_wp_q] <= tx_wr_data;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_wp_q <= 3'h0;
         tx_rp_q <= 3'h0;
         tx_cnt_q <= 4'h0;
      end else begin
         if (tx_push) tx_wp_q <= tx_wp_q + 3'h1;
         if (tx_pop) tx_rp_q <= tx_rp_q + 3'h1;
         tx_cnt_q <= tx_cnt_q + {3'h0, tx_push} - {3'h0, tx_pop};
      end
   end

   // receive fifo; a word arriving while full is dropped
   assign rx_rd_valid = rx_cnt_q != 4'h0;
   assign rx_rd_data = rx_mem[rx_rp_q];
   assign rx_pop = rx_rd_valid && rx_rd_ready;
   always_ff @(posedge ref_clk) begin
      if (word_done && rx_cnt_q != ssf_pkg::FIFO_FULL) begin
         rx_mem[rx_wp_q] <= rx_sh_q;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_wp_q <= 3'h0;
         rx_rp_q <= 3'h0;
         rx_cnt_q <= 4'h0;
      end else begin
         if (word_done && rx_cnt_q != ssf_pkg::FIFO_FULL) begin
            rx_wp_q <= rx_wp_q + 3'h1;
         end
         if (rx_pop) rx_rp_q <= rx_rp_q + 3'h1;
         rx_cnt_q <= rx_cnt_q + {3'h0, word_done && rx_cnt_q != ssf_pkg::FIFO_FULL}
            - {3'h0, rx_pop};
      end
   end

   // bit-rate divider: one half serial period per half_tick
   assign pre_lim = (ctl.prescale_divisor[7:1] == 7'h00) ? 7'h01 : ctl.prescale_divisor[7:1];
   assign start = state_q == ssf_pkg::ST_IDLE && ctl.enable && ctl.master_mode
      && tx_cnt_q != 4'h0;
   assign half_tick = !start && pre_q == pre_lim - 7'h01
      && rate_q == ctl.serial_rate_value;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= 7'h00;
         rate_q <= 8'h00;
      end else if (start) begin
         pre_q <= 7'h00;
         rate_q <= 8'h00;
      end else if (pre_q == pre_lim - 7'h01) begin
         pre_q <= 7'h00;
         rate_q <= (rate_q == ctl.serial_rate_value) ? 8'h00 : rate_q + 8'h01;
      end else begin
         pre_q <= pre_q + 7'h01;
      end
   end

   // frame geometry
   assign nbits = {1'b0, ctl.data_size_m1} + 5'h01;
   assign skip_bits = is_msg ? ssf_pkg::MSG_SKIP_BITS : 5'h00;
   assign last_half = {(nbits + skip_bits), 1'b0} - 6'h01;
   assign h_n = half_q + 6'h01;
   assign tx_pop = start || (word_done && more);
   assign more = ctl.enable && tx_cnt_q != 4'h0 && !is_msg
      && (is_pulse || ctl.clock_phase);
   assign word_done = state_q == ssf_pkg::ST_XFER && half_tick && half_q == last_half;
   // left-justify so the msb leaves first
   assign load_word = is_msg ? {tx_mem[tx_rp_q][7:0], 8'h00}
      : tx_mem[tx_rp_q] << (5'h10 - nbits);

   function automatic logic clk_level(input logic [5:0] h);
      if (is_pulse) return ~h[0];
      if (is_msg) return h[0];
      return ctl.clock_polarity ^ (ctl.clock_phase ? ~h[0] : h[0]);
   endfunction : clk_level

   // frame sequencer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ssf_pkg::ST_IDLE;
         half_q <= 6'h00;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         sclk_q <= 1'b0;
         fss_q <= 1'b1;
         dout_q <= 1'b0;
         doe_q <= 1'b0;
      end else begin
         case (state_q)
            ssf_pkg::ST_IDLE: begin
               sclk_q <= is_spi && ctl.clock_polarity;
               fss_q <= !is_pulse;
               dout_q <= 1'b0;
               doe_q <= !is_pulse;
               half_q <= 6'h00;
               if (start) begin
                  state_q <= ssf_pkg::ST_LEAD;
                  tx_sh_q <= load_word;
                  rx_sh_q <= 16'h0000;
                  fss_q <= is_pulse;
                  doe_q <= 1'b1;
                  sclk_q <= is_pulse || (is_spi && ctl.clock_polarity);
                  dout_q <= is_msg ? load_word[15] : 1'b0;
               end
            end
            ssf_pkg::ST_LEAD: begin
               if (half_tick) begin
                  half_q <= h_n;
                  if (!is_pulse || h_n == ssf_pkg::PULSE_LEAD_HALVES) begin
                     state_q <= ssf_pkg::ST_XFER;
                     half_q <= 6'h00;
                     fss_q <= 1'b0;
                     dout_q <= tx_sh_q[15];
                     sclk_q <= clk_level(6'h00);
                  end else begin
                     sclk_q <= 1'b0;
                  end
               end
            end
            ssf_pkg::ST_XFER: begin
               if (half_tick) begin
                  if (half_q == last_half) begin
                     if (more) begin
                        // pulse format reloads with a new pulse; phase 1 keeps select low
                        state_q <= is_pulse ? ssf_pkg::ST_LEAD : ssf_pkg::ST_XFER;
                        half_q <= 6'h00;
                        tx_sh_q <= load_word;
                        rx_sh_q <= 16'h0000;
                        fss_q <= is_pulse;
                        sclk_q <= is_pulse ? 1'b1 : clk_level(6'h00);
                        dout_q <= is_pulse ? dout_q : load_word[15];
                     end else begin
                        state_q <= ssf_pkg::ST_TAIL;
                        sclk_q <= is_pulse ? 1'b1 : clk_level(6'h00) ^ ctl.clock_phase;
                     end
                  end else begin
                     half_q <= h_n;
                     sclk_q <= clk_level(h_n);
                     if (h_n[0]) begin
                        // capture on odd half: rising for pol0 pha0, falling for pol0 pha1
                        if (h_n[5:1] >= skip_bits) begin
                           rx_sh_q <= {rx_sh_q[14:0], rx_sync_q};
                        end
                     end else begin
                        tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                        dout_q <= (is_msg && h_n[5:1] >= ssf_pkg::MSG_CTRL_BITS) ? 1'b0
                           : tx_sh_q[14];
                     end
                  end
               end
            end
            ssf_pkg::ST_TAIL: begin
               if (half_tick) begin
                  sclk_q <= is_spi && ctl.clock_polarity;
                  if (is_pulse) begin
                     state_q <= ssf_pkg::ST_IDLE;
                  end else begin
                     state_q <= ssf_pkg::ST_GAP;
                     fss_q <= 1'b1;
                  end
               end
            end
            ssf_pkg::ST_GAP: begin
               if (half_tick) begin
                  state_q <= ssf_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= ssf_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // receive timeout counts idle half periods while data waits
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         to_cnt_q <= 7'h00;
      end else if (state_q != ssf_pkg::ST_IDLE || rx_cnt_q == 4'h0) begin
         to_cnt_q <= 7'h00;
      end else if (half_tick && to_cnt_q != ssf_pkg::TIMEOUT_HALVES) begin
         to_cnt_q <= to_cnt_q + 7'h01;
      end
   end

   // sticky overrun, set wins over clear
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_q <= 1'b0;
      end else if (word_done && rx_cnt_q == ssf_pkg::FIFO_FULL) begin
         ovr_q <= 1'b1;
      end else if (overrun_clear) begin
         ovr_q <= 1'b0;
      end
   end

   // raw status register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_q <= ssf_pkg::RAW_RESET;
      end else begin
         raw_q[ssf_pkg::INT_OVERRUN] <= ovr_q;
         raw_q[ssf_pkg::INT_TIMEOUT] <= to_cnt_q == ssf_pkg::TIMEOUT_HALVES;
         raw_q[ssf_pkg::INT_RX] <= rx_cnt_q >= ssf_pkg::RX_SERVICE_LEVEL;
         raw_q[ssf_pkg::INT_TX] <= tx_cnt_q <= ssf_pkg::TX_SERVICE_LEVEL;
      end
   end

   assign raw_interrupt_status = raw_q;
   assign masked_interrupt_status = raw_q & interrupt_mask_reg;
   assign interrupt_request = |masked_interrupt_status;

   assign serial_clock_pin_o = sclk_q;
   assign serial_clock_pin_oe = ctl.master_mode;
   assign frame_select_pin_o = fss_q;
   assign frame_select_pin_oe = ctl.master_mode;
   assign serial_out_pin_o = dout_q;
   assign serial_out_pin_oe = doe_q;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_lead_end;
      state_q == ssf_pkg::ST_LEAD && half_tick
         && (!is_pulse || h_n == ssf_pkg::PULSE_LEAD_HALVES);
   endsequence
   sequence s_full_arrival;
      word_done && rx_cnt_q == ssf_pkg::FIFO_FULL;
   endsequence

   a_msb_first_out: assert property (s_lead_end |=> dout_q == $past(tx_sh_q[15]))
      else $error("first bit is not the word msb");
   a_overrun_raise: assert property (s_full_arrival |-> ##2 raw_interrupt_status[0])
      else $error("overrun not flagged");
   a_request_mask: assert property ((masked_interrupt_status & ~interrupt_mask_reg) == 4'h0
      && (interrupt_request == (raw_q != 4'h0 && (raw_q & interrupt_mask_reg) != 4'h0)))
      else $error("request does not follow masked status");
   a_timeout_data: assert property (raw_q[ssf_pkg::INT_TIMEOUT] |-> $past(rx_cnt_q, 2) != 4'h0)
      else $error("timeout without data waiting");
   a_select_low: assert property (state_q == ssf_pkg::ST_XFER && !is_pulse |-> !fss_q)
      else $error("select high inside frame");
   a_pulse_select: assert property ($rose(fss_q) && is_pulse |-> state_q == ssf_pkg::ST_LEAD
      ##1 fss_q)
      else $error("pulse select outside lead");
   a_pulse_idle: assert property (state_q == ssf_pkg::ST_IDLE && $past(state_q)
      == ssf_pkg::ST_IDLE && is_pulse && $stable(ctl) |-> !doe_q && !sclk_q && !fss_q)
      else $error("pulse format idle levels wrong");
   a_spi_idle_clock: assert property (state_q == ssf_pkg::ST_IDLE && $past(state_q)
      == ssf_pkg::ST_IDLE && is_spi && $stable(ctl) |-> sclk_q == ctl.clock_polarity
      && fss_q)
      else $error("spi idle clock or select wrong");
   a_msg_skip_rx: assert property (state_q == ssf_pkg::ST_XFER && is_msg && half_tick
      && half_q != last_half && h_n[5:1] < ssf_pkg::MSG_SKIP_BITS |=> $stable(rx_sh_q))
      else $error("message control phase captured data");
endmodule : ssf_engine
`default_nettype wire

// [ssf_slave_model.sv]
// ssf_slave_model: behavioural off-chip serial peripheral facing the frame engine
// assumes: master drives clock and select; lead = reply bits skipped before answering
`timescale 1ns/10ps
`default_nettype none
module ssf_slave_model (
   input wire logic sclk,
   input wire logic sel,
   input wire logic pol,
   input wire logic pha,
   input wire logic [4:0] lead,
   input wire logic [4:0] bits,
   input wire logic [15:0] reply,
   input wire logic sdi,
   output logic sdo,
   output logic [31:0] captured
);
   logic [31:0] sh = 32'h0;
   logic drv = 1'b0;
   wire logic eclk = sclk ^ pol ^ pha;
   // deselected line shows the inverse of the last bit
   assign sdo = sel ? ~drv : drv;
   // load reply msb first, skipping control and wait bits
   always @(negedge sel) begin
      sh = (({reply, 16'h0000} << (5'd16 - bits)) >> lead)
         | (32'haaaaaaaa & ~(32'hffffffff >> lead));
      captured = 32'h0;
      if (!pha) begin
         drv = sh[31];
         sh = sh << 1;
      end
   end
   // capture edge
   always @(posedge eclk) begin
      if (!sel) captured = {captured[30:0], sdi};
   end
   // change edge
   always @(negedge eclk) begin
      if (!sel) begin
         drv = sh[31];
         sh = sh << 1;
      end
   end
endmodule : ssf_slave_model
`default_nettype wire

// [sync_serial_frame_formats_test.sv]
// sync_serial_frame_formats_test: self-checking bench of the serial frame engine
// assumes: ssf_pkg, ssf_engine and ssf_slave_model compiled first
`timescale 1ns/10ps
`default_nettype none
module sync_serial_frame_formats_test;
   typedef struct packed {
      logic pol;
      logic pha;
      logic [4:0] bits;
      logic [15:0] tx;
      logic [15:0] rx;
   } ssf_row_t;
   ssf_row_t rows [4];
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   ssf_pkg::ssf_ctrl_t ctrl = '0;
   logic [3:0] mask = 4'h0;
   logic ovr_clr = 1'b0;
   logic tx_v = 1'b0;
   logic [15:0] tx_d = 16'h0000;
   logic rx_r = 1'b0;
   logic tx_rdy, rx_v, irq, sclk, sclk_oe, sel, sel_oe, sdo, sdo_oe, sdi;
   logic [15:0] rx_d;
   logic [3:0] raw, msk;
   logic [4:0] m_lead = 5'h00;
   logic [4:0] m_bits = 5'h08;
   logic [15:0] m_reply = 16'h0000;
   logic [31:0] cap, mk;
   logic sel_q = 1'b1;
   logic mon = 1'b0;
   int n_errors = 0;
   int check_count = 0;
   int n_fall = 0;
   int n_rise = 0;
   int n_hi = 0;
   always #2.5 ref_clk = ~ref_clk;
   ssf_engine u_ssf_engine (
      .ref_clk(ref_clk), .arst_n(arst_n), .control_zero_reg(ctrl),
      .interrupt_mask_reg(mask), .overrun_clear(ovr_clr),
      .tx_wr_valid(tx_v), .tx_wr_ready(tx_rdy), .tx_wr_data(tx_d),
      .rx_rd_valid(rx_v), .rx_rd_ready(rx_r), .rx_rd_data(rx_d),
      .raw_interrupt_status(raw), .masked_interrupt_status(msk), .interrupt_request(irq),
      .serial_clock_pin_o(sclk), .serial_clock_pin_oe(sclk_oe),
      .frame_select_pin_o(sel), .frame_select_pin_oe(sel_oe),
      .serial_out_pin_o(sdo), .serial_out_pin_oe(sdo_oe), .serial_in_pin(sdi)
   );
   ssf_slave_model u_ssf_slave_model (
      .sclk(sclk), .sel(sel), .pol(ctrl.clock_polarity), .pha(ctrl.clock_phase),
      .lead(m_lead), .bits(m_bits), .reply(m_reply), .sdi(sdo), .sdo(sdi), .captured(cap)
   );
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic hang(input string nm);
      $display("unexpected %s: expected done seen timeout", nm);
      n_errors++;
      test_done();
   endtask : hang
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic cfg(input logic en, input ssf_pkg::ssf_format_t f, input logic pol,
                      input logic pha, input logic [4:0] b);
      logic [4:0] m1;
      m1 = b - 5'd1;
      @(posedge ref_clk);
      ctrl <= '{en, 1'b1, f, pol, pha, m1[3:0], 8'h04, 8'h01};
      m_bits <= b;
      cyc(4);
   endtask : cfg
   task automatic put(input logic [15:0] w);
      int i;
      @(posedge ref_clk);
      tx_v <= 1'b1;
      tx_d <= w;
      for (i = 0; i < 4000; i++) begin
         @(posedge ref_clk);
         if (tx_rdy === 1'b1) break;
      end
      tx_v <= 1'b0;
      if (i == 4000) hang("tx write");
   endtask : put
   task automatic pop(input logic [15:0] exp, input logic chk);
      int i;
      for (i = 0; i < 4000; i++) begin
         @(posedge ref_clk);
         if (rx_v === 1'b1) break;
      end
      if (i == 4000) hang("rx read");
      if (chk) check("rx word", {16'h0, rx_d}, {16'h0, exp});
      rx_r <= 1'b1;
      @(posedge ref_clk);
      rx_r <= 1'b0;
   endtask : pop
   task automatic wait_bit(input int b);
      int i;
      for (i = 0; i < 4000; i++) begin
         @(posedge ref_clk);
         if (raw[b] === 1'b1) break;
      end
      if (i == 4000) hang("status bit");
   endtask : wait_bit
   // select edge counters and idle clock monitor
   always @(posedge ref_clk) begin
      sel_q <= sel;
      if (sel_q && !sel) n_fall++;
      if (!sel_q && sel) n_rise++;
      if (sel) n_hi++;
      if (mon && sel && sel_q) check("idle clock", sclk, ctrl.clock_polarity);
   end
   initial begin
      rows[0] = '{1'b0, 1'b0, 5'd4, 16'h0009, 16'h000a};
      rows[1] = '{1'b0, 1'b1, 5'd16, 16'hc3a5, 16'h5a3c};
      rows[2] = '{1'b1, 1'b0, 5'd8, 16'h00b7, 16'h004e};
      rows[3] = '{1'b1, 1'b1, 5'd13, 16'h1d2b, 16'h0ad4};
      cyc(10);
      arst_n <= 1'b1;
      cyc(2);
      check("tx service", {sel, raw}, 5'h18);
      $display("done reset");
      for (int r = 0; r < 4; r++) begin
         m_reply <= rows[r].rx;
         cfg(1'b1, ssf_pkg::FMT_SPI, rows[r].pol, rows[r].pha, rows[r].bits);
         mon <= 1'b1;
         mk = (32'h1 << rows[r].bits) - 32'h1;
         check("idle pins", {sclk, sel, sdo, sclk_oe}, {rows[r].pol, 3'b101});
         put(rows[r].tx);
         pop(rows[r].rx, 1'b1);
         cyc(12);
         check("slave saw", cap & mk, {16'h0, rows[r].tx} & mk);
         mon <= 1'b0;
      end
      $display("done formats");
      for (int p = 0; p < 2; p++) begin
         m_reply <= 16'h0033;
         cfg(1'b1, ssf_pkg::FMT_SPI, 1'b0, p[0], 5'd8);
         n_fall = 0;
         put(16'h00a1);
         put(16'h00a2);
         pop(16'h0033, 1'b1);
         pop(16'h0000, 1'b0);
         cyc(12);
         check("select drops", n_fall, p ? 1 : 2);
      end
      $display("done back to back");
      m_reply <= 16'h0b6d;
      m_lead <= 5'd9;
      cfg(1'b1, ssf_pkg::FMT_MSG, 1'b0, 1'b0, 5'd12);
      put(16'h0096);
      pop(16'h0b6d, 1'b1);
      cyc(12);
      check("control byte", (cap >> 13) & 32'hff, 32'h96);
      m_lead <= 5'd0;
      $display("done message");
      cfg(1'b1, ssf_pkg::FMT_PULSE, 1'b0, 1'b0, 5'd8);
      check("pulse idle", {sclk, sel, sdo_oe}, 3'b000);
      n_rise = 0;
      n_hi = 0;
      put(16'h005c);
      pop(16'h0000, 1'b0);
      cyc(12);
      check("pulse count", n_rise, 1);
      check("pulse width", n_hi, 8);
      $display("done pulse");
      m_reply <= 16'h00c5;
      cfg(1'b0, ssf_pkg::FMT_SPI, 1'b0, 1'b0, 5'd8);
      mask <= 4'h8;
      for (int i = 0; i < 5; i++) put(16'h0040 + 16'(i));
      cyc(2);
      check("tx level", {raw[3], msk, irq}, 6'h00);
      ctrl.master_mode <= 1'b0;
      cyc(2);
      check("slave pads", {sclk_oe, sel_oe}, 2'b00);
      cfg(1'b1, ssf_pkg::FMT_SPI, 1'b0, 1'b0, 5'd8);
      wait_bit(ssf_pkg::INT_TIMEOUT);
      check("timeout", {raw, msk, irq}, {4'he, 4'h8, 1'b1});
      for (int i = 0; i < 4; i++) put(16'h0050 + 16'(i));
      wait_bit(ssf_pkg::INT_OVERRUN);
      mask <= 4'h1;
      cyc(2);
      check("overrun irq", {msk, irq}, 5'h03);
      mask <= 4'h0;
      cyc(2);
      check("masked off", {msk, irq}, 5'h00);
      ovr_clr <= 1'b1;
      cyc(1);
      ovr_clr <= 1'b0;
      cyc(2);
      check("overrun clear", raw[0], 1'b0);
      for (int i = 0; i < 8; i++) pop(16'h00c5, 1'b1);
      cyc(3);
      check("rx empty", raw[2:1], 2'b00);
      $display("done status");
      put(16'h0011);
      cyc(10);
      arst_n <= 1'b0;
      cyc(2);
      check("reset pins", {sel, sclk, sdo, sdo_oe, rx_v, tx_rdy, raw}, 10'h210);
      arst_n <= 1'b1;
      cyc(4);
      check("after reset", {sel, raw}, 5'h18);
      $display("done mid reset");
      test_done();
   end
endmodule : sync_serial_frame_formats_test
`default_nettype wire
